// file: include/tcs_consts.vh
/*
  Constants for the timer 0 compare and shutdown register block:
  register byte addresses, field positions, reset values, codes.
  Assumes it is included by its bare name from the design files.
*/
`ifndef TCS_CONSTS_VH
`define TCS_CONSTS_VH

// Register byte addresses on the plain register port
`define TCS_ADDR_COUNT 8'h46
`define TCS_ADDR_CMP_A 8'h47
`define TCS_ADDR_CMP_B 8'h48
`define TCS_ADDR_SHUT_SEL 8'h49
`define TCS_ADDR_IRQ_MASK 8'h6e
`define TCS_ADDR_FLAGS 8'h35

// Reset value of every byte register
`define TCS_RST_BYTE 8'h00

// Implemented bits of the shutdown select register (bits 3:2 reserved)
`define TCS_SEL_MASK 8'hf3
`define TCS_SEL_T1OVF 7
`define TCS_SEL_T2OVF 6
`define TCS_SEL_PC0 5
`define TCS_SEL_EXT0 4
`define TCS_SEL_AC1 1
`define TCS_SEL_AC0 0

// Mask and flag bit positions, implemented bits
`define TCS_BIT_CMPB 2
`define TCS_BIT_CMPA 1
`define TCS_BIT_OVF 0
`define TCS_IRQ_BITS 8'h07

// Compare output mode codes
`define TCS_MODE_OFF 2'h0
`define TCS_MODE_KEEP 2'h1
`define TCS_MODE_CLR 2'h2
`define TCS_MODE_SET 2'h3

// Waveform mode fields: bit 0 marks PWM, bit 2 selects compare A as top
`define TCS_WGM_PWM_BIT 0
`define TCS_WGM_TOPA_BIT 2

// Counter limits
`define TCS_CNT_MAX 8'hff
`define TCS_CNT_BOTTOM 8'h00
`define TCS_CNT_ONE 8'h01

`endif

// file: src/tcs_cmp_chan.v
/*
  One output compare channel: active compare value, its buffer and
  the equality compare against the counter.
  Assumes the parent supplies the timer tick, the buffering mode and
  the boundary load pulse, all on clk_sys_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tcs_consts.vh"

module tcs_cmp_chan #(
  parameter WIDTH = 8
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire write_i,
  input wire [WIDTH-1:0] wdata_i,
  input wire buffered_i,
  input wire load_i,
  input wire tick_i,
  input wire quiet_i,
  input wire [WIDTH-1:0] count_i,
  output reg [WIDTH-1:0] active_o,
  output wire [WIDTH-1:0] cpu_view_o,
  output wire match_o
);

  reg [WIDTH-1:0] buffer_r; // Value waiting for the next boundary

  // Software sees the buffer while buffering, else the live value
  assign cpu_view_o = buffered_i ? buffer_r : active_o;

  // Match only on a timer tick that is not being suppressed
  assign match_o = tick_i & ~quiet_i & (count_i == active_o);

  // Active value: direct write when unbuffered, boundary load otherwise
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      active_o <= {WIDTH{1'b0}};
      buffer_r <= {WIDTH{1'b0}};
    end else begin
      if (write_i) begin
        buffer_r <= wdata_i;
      end
      if (write_i && !buffered_i) begin
        // Normal and clear-on-match modes take effect at once
        active_o <= wdata_i;
      end else if (buffered_i && load_i) begin
        // Only at the boundary, so a pulse is never cut short
        active_o <= buffer_r;
      end
    end
  end

endmodule
`default_nettype wire

// file: src/tcs_top.v
/*
  Timer 0 counter, compare A/B registers with PWM double buffering,
  automatic waveform shutdown from peer flags, interrupt mask, flags.
  Assumes the rest of the timer (prescaler, wave generator, dead time)
  and the peer peripherals run on clk_sys_i, and that the control
  register holding the mode and shutdown enable bits sits outside.
*/
// Function
// - Select bits 7,6,5: timer1, timer2, pin-change
// - Select bits 4,1,0: ext irq0, comparators
// - Enabled channel: selected flag rise kills output
// - Disabled channel ignores every selected source
// - Any selected source triggers shutdown independently
// - Dead time: channel B polarity from its mode
// - Dead time, A3 with B3: A follows B
// - Counter write suppresses next tick's compare match
// - Skipped compare match is never produced later
// - No clock: counter holds, software access works
// - Software count write beats clear/increment/decrement
// - Compare A continuously; match feeds flag, wave
// - Compare A buffered in PWM, direct otherwise
// - Buffered value loaded only at boundary
// - Software reaches buffer when buffering, else live
// - Compare B behaves like compare A
// - Compare B request: mask bit 2, global, flag
// - Compare A request: mask bit 1, global, flag
// - Overflow request: mask bit 0, global, flag
// - Shutdown clears affected channel's output mode bits
// - Flags clear on service or write-one
`timescale 1ns/1ps
`default_nettype none
`include "tcs_consts.vh"

module tcs_top #(
  parameter WIDTH = 8
) (
  input wire clk_sys_i,
  input wire reset_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // Timer core links
  input wire timer_tick_i,
  input wire [2:0] wave_mode_i,
  input wire count_clear_i,
  input wire count_inc_i,
  input wire count_dec_i,
  input wire overflow_event_i,
  input wire [1:0] output_mode_a_i,
  input wire [1:0] output_mode_b_i,
  input wire shutdown_enable_a_i,
  input wire shutdown_enable_b_i,
  input wire dead_time_enable_i,
  input wire wave_a_raw_i,
  input wire wave_b_raw_i,
  // Interrupt links
  input wire global_irq_enable_i,
  input wire ack_overflow_i,
  input wire ack_compare_a_i,
  input wire ack_compare_b_i,
  // Peer peripheral flags
  input wire timer1_overflow_flag_i,
  input wire timer2_overflow_flag_i,
  input wire pin_change0_flag_i,
  input wire ext_irq0_flag_i,
  input wire comparator1_flag_i,
  input wire comparator0_flag_i,
  // Results
  output reg [WIDTH-1:0] timer_count_value_o,
  output wire [WIDTH-1:0] compare_value_a_o,
  output wire [WIDTH-1:0] compare_value_b_o,
  output reg match_a_o,
  output reg match_b_o,
  output reg compare_a_flag_o,
  output reg compare_b_flag_o,
  output reg overflow_flag_o,
  output reg irq_req_overflow_o,
  output reg irq_req_compare_a_o,
  output reg irq_req_compare_b_o,
  output reg clear_mode_a_o,
  output reg clear_mode_b_o,
  output reg compare_wave_a_o,
  output reg compare_wave_a_en_o,
  output reg compare_wave_b_o,
  output reg compare_wave_b_en_o
);

  // Address decode strobes
  wire wr_count = wr_i && (addr_i == `TCS_ADDR_COUNT);
  wire wr_cmp_a = wr_i && (addr_i == `TCS_ADDR_CMP_A);
  wire wr_cmp_b = wr_i && (addr_i == `TCS_ADDR_CMP_B);
  wire wr_sel = wr_i && (addr_i == `TCS_ADDR_SHUT_SEL);
  wire wr_mask = wr_i && (addr_i == `TCS_ADDR_IRQ_MASK);
  wire wr_flags = wr_i && (addr_i == `TCS_ADDR_FLAGS);

  reg [7:0] shutdown_source_select_r; // Shutdown source enables
  reg [7:0] irq_mask_r; // Interrupt mask bits
  reg quiet_r; // Compare suppression after a count write
  reg [7:0] src_prev_r; // Peer flags one clock earlier
  reg [WIDTH-1:0] count_nxt; // Next counter value
  reg [7:0] rdata_nxt; // Next read data

  // PWM modes buffer the compare values
  wire pwm_mode = wave_mode_i[`TCS_WGM_PWM_BIT];

  // Channel outputs
  wire [WIDTH-1:0] view_a;
  wire [WIDTH-1:0] view_b;
  wire match_a;
  wire match_b;

  // Top of count: compare A in the modes that use it, else all ones
  wire [WIDTH-1:0] top_value = wave_mode_i[`TCS_WGM_TOPA_BIT] ?
    compare_value_a_o : {WIDTH{1'b1}};

  // Boundary pulse for the buffered compare values
  wire load_pulse = timer_tick_i && (timer_count_value_o == top_value);

  // Compare channel A
  tcs_cmp_chan #(
    .WIDTH(WIDTH)
  ) u_chan_a (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .write_i(wr_cmp_a),
    .wdata_i(wdata_i[WIDTH-1:0]),
    .buffered_i(pwm_mode),
    .load_i(load_pulse),
    .tick_i(timer_tick_i),
    .quiet_i(quiet_r),
    .count_i(timer_count_value_o),
    .active_o(compare_value_a_o),
    .cpu_view_o(view_a),
    .match_o(match_a)
  );

  // Compare channel B, same structure as A
  tcs_cmp_chan #(
    .WIDTH(WIDTH)
  ) u_chan_b (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .write_i(wr_cmp_b),
    .wdata_i(wdata_i[WIDTH-1:0]),
    .buffered_i(pwm_mode),
    .load_i(load_pulse),
    .tick_i(timer_tick_i),
    .quiet_i(quiet_r),
    .count_i(timer_count_value_o),
    .active_o(compare_value_b_o),
    .cpu_view_o(view_b),
    .match_o(match_b)
  );

  // Peer flags gathered at their select bit positions
  wire [7:0] src_now = {
    timer1_overflow_flag_i,
    timer2_overflow_flag_i,
    pin_change0_flag_i,
    ext_irq0_flag_i,
    2'b00,
    comparator1_flag_i,
    comparator0_flag_i
  };

  // Rising edge of each selected source, each on its own
  wire [7:0] src_rise = src_now & ~src_prev_r &
    shutdown_source_select_r;

  // Any single rise is enough to shut down
  wire shut_event = |src_rise;

  // Flag set and clear terms
  wire set_ovf = timer_tick_i && overflow_event_i;
  wire clr_ovf = ack_overflow_i ||
    (wr_flags && wdata_i[`TCS_BIT_OVF]);
  wire clr_cmpa = ack_compare_a_i ||
    (wr_flags && wdata_i[`TCS_BIT_CMPA]);
  wire clr_cmpb = ack_compare_b_i ||
    (wr_flags && wdata_i[`TCS_BIT_CMPB]);

  // Counter next value; a software write takes priority
  always @* begin
    count_nxt = timer_count_value_o;
    if (wr_count) begin
      count_nxt = wdata_i[WIDTH-1:0];
    end else if (timer_tick_i) begin
      if (count_clear_i) begin
        count_nxt = {WIDTH{1'b0}};
      end else if (count_inc_i) begin
        count_nxt = timer_count_value_o + {{(WIDTH-1){1'b0}}, 1'b1};
      end else if (count_dec_i) begin
        count_nxt = timer_count_value_o - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end else begin
      // No tick, no clock source: value simply holds
      count_nxt = timer_count_value_o;
    end
  end

  // Counter register and compare suppression
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      timer_count_value_o <= {WIDTH{1'b0}};
      quiet_r <= 1'b0;
    end else begin
      timer_count_value_o <= count_nxt;
      if (wr_count) begin
        // Holds even while stopped until the next tick arrives
        quiet_r <= 1'b1;
      end else if (timer_tick_i) begin
        quiet_r <= 1'b0;
      end
    end
  end

  // Registered compare matches; equality only, so a value jumped
  // over by a write is never matched after the fact
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      match_a_o <= 1'b0;
      match_b_o <= 1'b0;
    end else begin
      match_a_o <= match_a;
      match_b_o <= match_b;
    end
  end

  // Software control registers
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      shutdown_source_select_r <= `TCS_RST_BYTE;
      irq_mask_r <= `TCS_RST_BYTE;
    end else begin
      if (wr_sel) begin
        // Reserved bits 3:2 never store
        shutdown_source_select_r <= wdata_i & `TCS_SEL_MASK;
      end
      if (wr_mask) begin
        irq_mask_r <= wdata_i & `TCS_IRQ_BITS;
      end
    end
  end

  // Flags: a set in the same cycle as a clear wins
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      overflow_flag_o <= 1'b0;
      compare_a_flag_o <= 1'b0;
      compare_b_flag_o <= 1'b0;
    end else begin
      if (set_ovf) begin
        overflow_flag_o <= 1'b1;
      end else if (clr_ovf) begin
        overflow_flag_o <= 1'b0;
      end
      if (match_a) begin
        compare_a_flag_o <= 1'b1;
      end else if (clr_cmpa) begin
        compare_a_flag_o <= 1'b0;
      end
      if (match_b) begin
        compare_b_flag_o <= 1'b1;
      end else if (clr_cmpb) begin
        compare_b_flag_o <= 1'b0;
      end
    end
  end

  // Interrupt requests follow flag, mask and global enable
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      irq_req_overflow_o <= 1'b0;
      irq_req_compare_a_o <= 1'b0;
      irq_req_compare_b_o <= 1'b0;
    end else begin
      irq_req_compare_b_o <= irq_mask_r[`TCS_BIT_CMPB] &&
        global_irq_enable_i && compare_b_flag_o;
      irq_req_compare_a_o <= irq_mask_r[`TCS_BIT_CMPA] &&
        global_irq_enable_i && compare_a_flag_o;
      irq_req_overflow_o <= irq_mask_r[`TCS_BIT_OVF] &&
        global_irq_enable_i && overflow_flag_o;
    end
  end

  // Shutdown edge memory and mode clear pulses
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      src_prev_r <= 8'h00;
      clear_mode_a_o <= 1'b0;
      clear_mode_b_o <= 1'b0;
    end else begin
      src_prev_r <= src_now;
      // Disabled channel never reacts, whatever is selected
      clear_mode_a_o <= shut_event && shutdown_enable_a_i;
      clear_mode_b_o <= shut_event && shutdown_enable_b_i;
    end
  end

  // Output waveforms; A takes B's waveform, inverted when A's clear/set mode differs from B's, when dead time is on
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      compare_wave_a_o <= 1'b0;
      compare_wave_a_en_o <= 1'b0;
      compare_wave_b_o <= 1'b0;
      compare_wave_b_en_o <= 1'b0;
    end else begin
      // B is governed by its own mode alone, dead time or not
      compare_wave_b_o <= wave_b_raw_i;
      // Gate at once on a shutdown so no edge slips out
      compare_wave_b_en_o <= (output_mode_b_i != `TCS_MODE_OFF) &&
        !(shut_event && shutdown_enable_b_i);
      if (!dead_time_enable_i) begin
        compare_wave_a_o <= wave_a_raw_i;
        compare_wave_a_en_o <= (output_mode_a_i != `TCS_MODE_OFF) &&
          !(shut_event && shutdown_enable_a_i);
      end else begin
        // Equal A and B codes give same polarity, unequal opposite
        case (output_mode_a_i)
          `TCS_MODE_CLR, `TCS_MODE_SET: begin
            compare_wave_a_o <= (output_mode_a_i == output_mode_b_i) ?
              wave_b_raw_i : ~wave_b_raw_i;
          end
          default: begin
            // Off and the unused code leave the pin to the port
            compare_wave_a_o <= wave_b_raw_i;
          end
        endcase
        compare_wave_a_en_o <= output_mode_a_i[1] &&
          !(shut_event && shutdown_enable_a_i);
      end
    end
  end

  // Read data mux; unmapped addresses and idle cycles read zero
  always @* begin
    rdata_nxt = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `TCS_ADDR_COUNT: begin
          rdata_nxt = timer_count_value_o;
        end
        `TCS_ADDR_CMP_A: begin
          rdata_nxt = view_a;
        end
        `TCS_ADDR_CMP_B: begin
          rdata_nxt = view_b;
        end
        `TCS_ADDR_SHUT_SEL: begin
          rdata_nxt = shutdown_source_select_r;
        end
        `TCS_ADDR_IRQ_MASK: begin
          rdata_nxt = irq_mask_r;
        end
        `TCS_ADDR_FLAGS: begin
          rdata_nxt = {5'h00, compare_b_flag_o, compare_a_flag_o,
            overflow_flag_o};
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  // Read data stands the cycle after the strobe only
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rdata_nxt;
    end
  end

endmodule
`default_nettype wire

// file: sim/tcs_peer.sv
/*
  Peer peripheral flag model: six interrupt flags of other blocks.
  Assumes the bench pulses fire_i and clear_i on clk_sys_i.
*/
`timescale 1ns/1ps
`default_nettype none
module tcs_peer (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [5:0] fire_i,
  input wire logic [5:0] clear_i,
  output logic [5:0] flags_o
);
  // A flag stays set until software clears it, as real flags do
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      flags_o <= 6'h00;
    end else begin
      flags_o <= (flags_o | fire_i) & ~clear_i;
    end
  end
endmodule
`default_nettype wire

// file: sim/tcs_monitor.sv
/*
  Checker for the timer 0 compare and shutdown block.
  Assumes one clock domain; bound onto every instance of tcs_top.
*/
`timescale 1ns/1ps
`default_nettype none
module tcs_monitor (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic timer_tick_i,
  input wire logic global_irq_enable_i,
  input wire logic shutdown_enable_a_i,
  input wire logic timer1_overflow_flag_i,
  input wire logic timer2_overflow_flag_i,
  input wire logic pin_change0_flag_i,
  input wire logic ext_irq0_flag_i,
  input wire logic comparator1_flag_i,
  input wire logic comparator0_flag_i,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] timer_count_value_o,
  input wire logic match_a_o,
  input wire logic match_b_o,
  input wire logic compare_a_flag_o,
  input wire logic compare_b_flag_o,
  input wire logic overflow_flag_o,
  input wire logic irq_req_overflow_o,
  input wire logic irq_req_compare_a_o,
  input wire logic irq_req_compare_b_o,
  input wire logic clear_mode_a_o,
  input wire logic compare_wave_a_en_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  wire [5:0] pk = {timer1_overflow_flag_i, timer2_overflow_flag_i,
    pin_change0_flag_i, ext_irq0_flag_i, comparator1_flag_i,
    comparator0_flag_i};
  logic [5:0] pk_q; // Peer flags one clock back
  // Own edge reference, so a stuck design edge memory shows up
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      pk_q <= 6'h00;
    end else begin
      pk_q <= pk;
    end
  end
  a_read_slot: assert property (rdata_o != 8'h00 |-> $past(rd_i))
    else $error("read data outside its slot");
  a_count_hold: assert property
    (!$past(timer_tick_i) && !$past(wr_i) |-> $stable(timer_count_value_o))
    else $error("counter moved without tick or write");
  a_match_a_flag: assert property (match_a_o |-> compare_a_flag_o)
    else $error("compare A match without flag");
  a_match_b_flag: assert property (match_b_o |-> compare_b_flag_o)
    else $error("compare B match without flag");
  a_irq_ovf_cause: assert property
    (irq_req_overflow_o |-> $past(overflow_flag_o && global_irq_enable_i))
    else $error("overflow request without cause");
  a_irq_cmpa_cause: assert property
    (irq_req_compare_a_o |-> $past(compare_a_flag_o && global_irq_enable_i))
    else $error("compare A request without cause");
  a_irq_cmpb_cause: assert property
    (irq_req_compare_b_o |-> $past(compare_b_flag_o && global_irq_enable_i))
    else $error("compare B request without cause");
  a_shut_disabled: assert property
    (!$past(shutdown_enable_a_i) |-> !clear_mode_a_o)
    else $error("shutdown on disabled channel");
  a_shut_on_rise: assert property
    (clear_mode_a_o |-> $past(|(pk & ~pk_q)) && !compare_wave_a_en_o)
    else $error("shutdown without rising peer flag");
  cover property (clear_mode_a_o);
  cover property (match_b_o);
  cover property (irq_req_compare_a_o);
endmodule
bind tcs_top tcs_monitor tcs_monitor_i (.*);
`default_nettype wire

// file: sim/tb_top.sv
/*
  Self-checking bench for tcs_top with a register model and peer flags.
  Assumes tcs_top with default width and the tcs_peer model.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic clk_sys_i = 0, reset_i = 1, wr_i = 0, rd_i = 0;
  logic [7:0] addr_i = 0, wdata_i = 0, rdata_o;
  logic timer_tick_i = 0, count_clear_i = 0, count_inc_i = 0;
  logic count_dec_i = 0, overflow_event_i = 0;
  logic [2:0] wave_mode_i = 0;
  logic [1:0] output_mode_a_i = 0, output_mode_b_i = 0;
  logic shutdown_enable_a_i = 0, shutdown_enable_b_i = 0;
  logic dead_time_enable_i = 0, wave_a_raw_i = 0, wave_b_raw_i = 0;
  logic global_irq_enable_i = 0, ack_overflow_i = 0;
  logic ack_compare_a_i = 0, ack_compare_b_i = 0;
  logic timer1_overflow_flag_i, timer2_overflow_flag_i;
  logic pin_change0_flag_i, ext_irq0_flag_i;
  logic comparator1_flag_i, comparator0_flag_i;
  logic [7:0] timer_count_value_o, compare_value_a_o, compare_value_b_o;
  logic match_a_o, match_b_o, compare_a_flag_o, compare_b_flag_o;
  logic overflow_flag_o, irq_req_overflow_o, irq_req_compare_a_o;
  logic irq_req_compare_b_o, clear_mode_a_o, clear_mode_b_o;
  logic compare_wave_a_o, compare_wave_a_en_o;
  logic compare_wave_b_o, compare_wave_b_en_o;
  logic [5:0] fire = 0, fclr = 0, pk;
  logic sa, sbb; // Shutdown pulses seen per channel
  int fails = 0, n_checks = 0, seed = 55740, k, e, c, sel;
  int mdl[int]; // Expected register contents by address
  int sb[6] = '{0, 1, 4, 5, 6, 7}; // Select bit of each peer flag
  int ra[5] = '{'h46, 'h47, 'h48, 'h49, 'h6e};
  int rm[5] = '{'hff, 'hff, 'hff, 'hf3, 'h07}; // Writable bits
  assign {timer1_overflow_flag_i, timer2_overflow_flag_i,
    pin_change0_flag_i, ext_irq0_flag_i, comparator1_flag_i,
    comparator0_flag_i} = pk;
  tcs_top tcs_top_i (.*);
  tcs_peer tcs_peer_i (.clk_sys_i, .reset_i, .fire_i(fire),
    .clear_i(fclr), .flags_o(pk));
  always #2 clk_sys_i = ~clk_sys_i;
  // Timer core strobes: {overflow, tick, clear, inc, dec}
  task automatic ops(input logic [4:0] o);
    {overflow_event_i, timer_tick_i, count_clear_i, count_inc_i,
      count_dec_i} <= o;
  endtask
  // One bus write, optionally beside timer strobes
  task automatic wr(input int a, input int d, input logic [4:0] o);
    @(posedge clk_sys_i);
    addr_i <= a[7:0];
    wdata_i <= d[7:0];
    wr_i <= 1'b1;
    ops(o);
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    ops(5'h00);
    foreach (ra[i]) begin
      if (ra[i] == a) mdl[a] = d & rm[i];
    end
    #1 `CHK(timer_count_value_o, 8'(mdl['h46]))
  endtask
  // One bus read; data stand only in the following cycle
  task automatic rd(input int a);
    @(posedge clk_sys_i);
    addr_i <= a[7:0];
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 `CHK(rdata_o, 8'(mdl.exists(a) ? mdl[a] : 0))
  endtask
  // One timer clock with the given count operation
  task automatic tk(input logic [4:0] o);
    @(posedge clk_sys_i);
    ops(o);
    @(posedge clk_sys_i);
    ops(5'h00);
    if (o[2]) mdl['h46] = 0;
    else if (o[1]) mdl['h46] = (mdl['h46] + 1) & 'hff;
    else if (o[0]) mdl['h46] = (mdl['h46] - 1) & 'hff;
    #1 `CHK(timer_count_value_o, 8'(mdl['h46]))
  endtask
  // One service pulse: {overflow, compare A, compare B}
  task automatic svc(input logic [2:0] a);
    @(posedge clk_sys_i);
    {ack_overflow_i, ack_compare_a_i, ack_compare_b_i} <= a;
    @(posedge clk_sys_i);
    {ack_overflow_i, ack_compare_a_i, ack_compare_b_i} <= 3'h0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    fails++;
    complete_run();
  end
  initial begin
    foreach (ra[i]) mdl[ra[i]] = 0;
    repeat (16) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    foreach (ra[i]) rd(ra[i]);
    wr('h50, 'hff, 0);
    rd('h50);
    repeat (12) begin
      k = ($random(seed) & 'h7fffffff) % 5;
      wr(ra[k], $random(seed), 0);
      rd(ra[k]);
    end
    for (int j = 0; j < 3; j++) wr('h46, 'h80 + j, 5'h08 | (5'h04 >> j));
    // Count written equal to compare, timer stopped a while: the
    // first tick stays silent, the second one matches
    wr('h47, 5, 0);
    wr('h48, 5, 0);
    wr('h6e, 'h07, 0);
    wr('h35, 'h07, 0);
    @(posedge clk_sys_i);
    global_irq_enable_i <= 1'b1;
    wr('h46, 5, 0);
    repeat (5) @(posedge clk_sys_i);
    tk(5'h08);
    `CHK(compare_a_flag_o, 1'b0)
    `CHK(match_b_o, 1'b0)
    tk(5'h08);
    `CHK(compare_a_flag_o, 1'b1)
    `CHK(match_a_o, 1'b1)
    `CHK(compare_b_flag_o, 1'b1)
    `CHK(match_b_o, 1'b1)
    @(posedge clk_sys_i);
    #1 `CHK(irq_req_compare_a_o, 1'b1)
    `CHK(irq_req_compare_b_o, 1'b1)
    `CHK(match_a_o, 1'b0)
    // Requests drop with global enable off, then with the mask bit
    @(posedge clk_sys_i);
    global_irq_enable_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 `CHK(irq_req_compare_b_o, 1'b0)
    wr('h6e, 'h03, 0);
    @(posedge clk_sys_i);
    global_irq_enable_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1 `CHK(irq_req_compare_b_o, 1'b0)
    `CHK(irq_req_compare_a_o, 1'b1)
    svc(3'h2);
    #1 `CHK(compare_a_flag_o, 1'b0)
    `CHK(compare_b_flag_o, 1'b1)
    svc(3'h1);
    #1 `CHK(compare_b_flag_o, 1'b0)
    wr('h46, 6, 0);
    repeat (3) tk(5'h0a);
    `CHK(compare_a_flag_o, 1'b0)
    `CHK(compare_b_flag_o, 1'b0)
    tk(5'h18);
    `CHK(overflow_flag_o, 1'b1)
    @(posedge clk_sys_i);
    #1 `CHK(irq_req_overflow_o, 1'b1)
    // Service and a new overflow in one cycle: the set wins
    @(posedge clk_sys_i);
    ack_overflow_i <= 1'b1;
    ops(5'h18);
    @(posedge clk_sys_i);
    ack_overflow_i <= 1'b0;
    ops(5'h00);
    #1 `CHK(overflow_flag_o, 1'b1)
    wr('h35, 'h01, 0);
    `CHK(overflow_flag_o, 1'b0)
    // PWM: writes reach the buffer, loaded at the top of the count
    @(posedge clk_sys_i);
    wave_mode_i <= 3'h1;
    wr('h47, 9, 0);
    `CHK(compare_value_a_o, 8'h05)
    rd('h47);
    wr('h46, 'hff, 0);
    tk(5'h08);
    `CHK(compare_value_a_o, 8'h09)
    // Top taken from compare A: the load follows that top
    @(posedge clk_sys_i);
    wave_mode_i <= 3'h5;
    wr('h47, 'h20, 0);
    wr('h46, 9, 0);
    tk(5'h08);
    `CHK(compare_value_a_o, 8'h20)
    `CHK(compare_value_b_o, 8'h05)
    for (int m = 0; m < 16; m++) begin
      @(posedge clk_sys_i);
      wave_mode_i <= 3'h0;
      dead_time_enable_i <= m[3];
      output_mode_a_i <= {1'b1, m[0]};
      output_mode_b_i <= {1'b1, m[1]};
      wave_a_raw_i <= !m[2];
      wave_b_raw_i <= m[2];
      repeat (3) @(posedge clk_sys_i);
      #1 `CHK(compare_wave_a_o, m[3] ? m[2] ^ m[0] ^ m[1] : !m[2])
      `CHK(compare_wave_b_o, m[2])
      `CHK(compare_wave_a_en_o, 1'b1)
      `CHK(compare_wave_b_en_o, 1'b1)
    end
    // Each peer flag: alone, among all, and left out of the select
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 6; j++) begin
        e = j % 2;
        c = j / 2;
        sel = c == 0 ? 1 << sb[i] : c == 1 ? 'hf3 : 'hf3 & ~(1 << sb[i]);
        wr('h49, sel, 0);
        @(posedge clk_sys_i);
        shutdown_enable_a_i <= e[0];
        shutdown_enable_b_i <= !e[0];
        fire <= 6'(1 << i);
        sa = 1'b0;
        sbb = 1'b0;
        repeat (4) begin
          @(posedge clk_sys_i);
          fire <= 6'h00;
          #1 sa = sa | clear_mode_a_o;
          sbb = sbb | clear_mode_b_o;
        end
        `CHK(sa, 1'(e == 1 && c != 2))
        `CHK(sbb, 1'(e == 0 && c != 2))
        fclr <= 6'h3f;
        @(posedge clk_sys_i);
        fclr <= 6'h00;
        @(posedge clk_sys_i);
      end
    end
    complete_run();
  end
endmodule
`default_nettype wire
